// ===== pkg/fdc_regs_pkg.sv
// Constants shared by the floppy register bank and its testbench.
// Assumes an eight-byte host I/O window decoded on the three low address bits.
package fdc_regs_pkg;

    // Host I/O offsets from the base address.
    localparam logic [2:0] OFS_MONITOR_A = 3'h0;
    localparam logic [2:0] OFS_MONITOR_B = 3'h1;
    localparam logic [2:0] OFS_DRIVE_OUT = 3'h2;
    localparam logic [2:0] OFS_TAPE_ASSIGN = 3'h3;
    localparam logic [2:0] OFS_STATUS_RATE = 3'h4;
    localparam logic [2:0] OFS_FIFO = 3'h5;
    localparam logic [2:0] OFS_INPUT_CONFIG = 3'h7;

    // Drive output control field positions.
    localparam int DO_SEL_LSB = 0;
    localparam int DO_RESET_N_BIT = 2;
    localparam int DO_DMA_EN_BIT = 3;
    localparam int DO_MOTOR_LSB = 4;

    // Main status bit positions.
    localparam int MS_RQM_BIT = 7;
    localparam int MS_DIO_BIT = 6;
    localparam int MS_BUSY_BIT = 4;

    // Values after reset.
    localparam logic [7:0] DRIVE_OUT_RESET = 8'h00;
    localparam logic [1:0] TAPE_SEL_RESET = 2'h0;
    localparam logic [1:0] DATA_RATE_RESET = 2'h2;
    localparam logic [7:0] SPECIFY_RESET = 8'h00;

    // Command codes recognised by the command phase.
    localparam logic [7:0] CMD_SPECIFY = 8'h03;
    localparam logic [7:0] CMD_SENSE_DRIVE = 8'h04;
    localparam logic [7:0] CMD_DUMP_REGS = 8'h0E;

    // Result bytes and counts.
    localparam logic [7:0] ST0_INVALID = 8'h80;
    localparam logic [3:0] DUMP_COUNT = 4'hA;
    localparam logic [3:0] SENSE_COUNT = 4'h1;
    localparam logic [3:0] INVALID_COUNT = 4'h1;
    localparam logic [1:0] SPECIFY_PARAMS = 2'h2;
    localparam logic [1:0] SENSE_PARAMS = 2'h1;

    // Command phase states.
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_PARAM,
        PH_RESULT
    } phase_t;

endpackage

// ===== hw/pin_edge_toggle.sv
// Pin monitor cell: optional two-flop synchroniser, a latched level and an edge toggle.
// Assumes a single clock; SYNC=1 for pins from outside the clock domain.
`timescale 1ns/1ps
module pin_edge_toggle #(
    parameter bit SYNC = 1'b1
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic pin_in,
    output logic level_q,
    output logic toggle_q
);

    logic meta_q;
    logic meta_d;
    logic level_d;
    logic toggle_d;
    logic stage_in;
    logic hist_q;
    logic hist_d;

    // Optional first stage feeds only the level flop; edges are seen on settled levels.
    always_comb begin
        meta_d = pin_in;
        stage_in = SYNC ? meta_q : pin_in;
        level_d = stage_in;
        hist_d = level_q;
        toggle_d = toggle_q ^ (level_q & ~hist_q);
    end

    // Pin registers reset to the idle high level and the toggle to zero, so release of reset makes no false edge.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            meta_q <= 1'b1;
            level_q <= 1'b1;
            hist_q <= 1'b1;
            toggle_q <= 1'b0;
        end else begin
            meta_q <= meta_d;
            level_q <= level_d;
            hist_q <= hist_d;
            toggle_q <= toggle_d;
        end
    end

    // A rising edge on the settled level flips the toggle one edge later.
    a_toggle_on_rise: assert property (@(posedge clock) disable iff (rst)
        (level_q && !hist_q) |=> (toggle_q != $past(toggle_q)))
        else $error("toggle did not flip on a rising pin edge");

endmodule

// ===== hw/floppy_status_command_regs.sv
// Host register bank of the floppy controller: pin monitors, drive output,
// tape assignment, main status, data rate and a small command phase.
// Assumes one-cycle host strobes on clock; core signals share this clock.
`timescale 1ns/1ps
// Contract
// - Decode offsets 0,1,2,3,4,5,7 to monitor A/B, drive out, tape, status, FIFO, config.
// - First layout monitor A: bit7 interrupt, bit5 inverted step, bit3 inverted head.
// - First layout monitor A: second drive, track zero, index, write protect, direction.
// - Alternate monitor A: bit6 request pin, bit5 latched step inverted, tracks, index inverted.
// - Alternate monitor A: bit3 head pin level, bit1 protected high, bit0 inward low.
// - First layout monitor B: bit5 drive select bit0, write gate, motors inverted.
// - First layout monitor B: bits 4 and 3 toggle on write/read data rising edges.
// - Alternate monitor B: second drive, drive A/B select levels, C/D select levels in bits 1:0.
// - Alternate monitor B bits 4..2 show inverted latched write, read, gate pins.
// - Drive output register is write-only and cleared by master reset.
// - Tape bits 1:0 map tape to logical drive 1..3 or none.
// - Only tape bits 1:0 exist unless three-mode is enabled.
// - Three-mode tape bits 7:6 show media id from config bits 3:2.
// - Three-mode tape bits 5:4 show drive type of last selected drive.
// - Three-mode tape bits 3:2 show boot drive from config bits 1:0.
// - Dump command places cylinders, timings, sectors, lock and FIFO settings in results.
// - Sense drive status takes one parameter byte, returns one status byte.
// - Unknown command does nothing, enters standby, returns one byte 80 hex.
module floppy_status_command_regs (
    input wire logic clock,
    input wire logic rst,
    input wire logic [2:0] host_addr,
    input wire logic host_cs,
    input wire logic host_rd,
    input wire logic host_wr,
    input wire logic [7:0] host_wdata,
    output logic [7:0] host_rdata_q,
    output logic host_rdata_oe,
    input wire logic alt_compat_mode,
    input wire logic three_mode_enable,
    input wire logic [7:0] drive_type_config_reg,
    input wire logic [7:0] media_boot_config_reg,
    input wire logic fdc_interrupt,
    input wire logic transfer_request_pin,
    input wire logic step_pulse_pin_n,
    input wire logic step_inward,
    input wire logic side_select_pin_n,
    input wire logic write_gate_pin_n,
    input wire logic write_data_pin_n,
    input wire logic read_data_pin_n,
    input wire logic second_drive_present_n,
    input wire logic track_zero_input_n,
    input wire logic index_pulse_signal_n,
    input wire logic write_protect_input_n,
    input wire logic disk_change_n,
    input wire logic [31:0] present_cylinder,
    input wire logic [7:0] sectors_per_track,
    input wire logic [7:0] perpendicular_settings,
    input wire logic [7:0] fifo_settings,
    input wire logic [7:0] precomp_start_track,
    output logic motor_a_pin_n,
    output logic motor_b_pin_n,
    output logic drive_a_select_pin_n,
    output logic drive_b_select_pin_n,
    output logic drive_c_select_pin_n,
    output logic drive_d_select_pin_n,
    output logic dma_irq_enable,
    output logic controller_reset_n,
    output logic [1:0] data_rate,
    output logic non_dma_flag,
    output logic controller_standby
);

    // Pin synchronisers: first and second stage for drive-side inputs.
    logic [4:0] pin_meta_q;
    logic [4:0] pin_sync_q;
    logic [4:0] pin_meta_d;
    logic [4:0] pin_sync_d;
    logic two_drv_n;
    logic trk0_n;
    logic index_n;
    logic wprot_n;
    logic dskchg_n;

    always_comb begin
        pin_meta_d = {disk_change_n, write_protect_input_n, index_pulse_signal_n,
                      track_zero_input_n, second_drive_present_n};
        pin_sync_d = pin_meta_q;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pin_meta_q <= 5'h1F;
            pin_sync_q <= 5'h1F;
        end else begin
            pin_meta_q <= pin_meta_d;
            pin_sync_q <= pin_sync_d;
        end
    end

    assign two_drv_n = pin_sync_q[0];
    assign trk0_n = pin_sync_q[1];
    assign index_n = pin_sync_q[2];
    assign wprot_n = pin_sync_q[3];
    assign dskchg_n = pin_sync_q[4];

    // Latched pin levels and toggles for write data, read data and step/gate.
    logic wd_level;
    logic wd_toggle;
    logic rd_level;
    logic rd_toggle;
    logic step_latch_q;
    logic gate_latch_q;

    pin_edge_toggle #(.SYNC(1'b0)) u_write_data (
        .clock(clock),
        .rst(rst),
        .pin_in(write_data_pin_n),
        .level_q(wd_level),
        .toggle_q(wd_toggle)
    );

    pin_edge_toggle #(.SYNC(1'b1)) u_read_data (
        .clock(clock),
        .rst(rst),
        .pin_in(read_data_pin_n),
        .level_q(rd_level),
        .toggle_q(rd_toggle)
    );

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            step_latch_q <= 1'b1;
            gate_latch_q <= 1'b1;
        end else begin
            step_latch_q <= step_pulse_pin_n;
            gate_latch_q <= write_gate_pin_n;
        end
    end

    // Host access decode.
    logic rd_en;
    logic wr_en;
    assign rd_en = host_cs & host_rd;
    assign wr_en = host_cs & host_wr;

    // Writable registers: drive output, tape select, data rate, specify bytes.
    logic [7:0] do_q;
    logic [7:0] do_d;
    logic [1:0] tape_q;
    logic [1:0] tape_d;
    logic [1:0] rate_q;
    logic [1:0] rate_d;
    logic [7:0] spec_a_q;
    logic [7:0] spec_a_d;
    logic [7:0] spec_b_q;
    logic [7:0] spec_b_d;

    // Command phase state.
    fdc_regs_pkg::phase_t phase_q;
    fdc_regs_pkg::phase_t phase_d;
    logic [7:0] cmd_q;
    logic [7:0] cmd_d;
    logic [1:0] pcnt_q;
    logic [1:0] pcnt_d;
    logic [3:0] rcnt_q;
    logic [3:0] rcnt_d;
    logic [3:0] ridx_q;
    logic [3:0] ridx_d;
    logic [7:0] res_q [0:9];
    logic [7:0] res_d [0:9];
    logic standby_q;
    logic standby_d;
    logic [7:0] st3;
    logic fifo_wr;
    logic fifo_rd;

    assign fifo_wr = wr_en && host_addr == fdc_regs_pkg::OFS_FIFO;
    assign fifo_rd = rd_en && host_addr == fdc_regs_pkg::OFS_FIFO;

    // Register writes; monitor offsets have no write path at all.
    always_comb begin
        do_d = do_q;
        tape_d = tape_q;
        rate_d = rate_q;
        if (wr_en && host_addr == fdc_regs_pkg::OFS_DRIVE_OUT) begin
            do_d = host_wdata;
        end
        if (wr_en && host_addr == fdc_regs_pkg::OFS_TAPE_ASSIGN) begin
            tape_d = host_wdata[1:0];
        end
        if (wr_en && (host_addr == fdc_regs_pkg::OFS_STATUS_RATE ||
                      host_addr == fdc_regs_pkg::OFS_INPUT_CONFIG)) begin
            rate_d = host_wdata[1:0];
        end
    end

    // Master reset clears the drive output register.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            do_q <= fdc_regs_pkg::DRIVE_OUT_RESET;
            tape_q <= fdc_regs_pkg::TAPE_SEL_RESET;
            rate_q <= fdc_regs_pkg::DATA_RATE_RESET;
        end else begin
            do_q <= do_d;
            tape_q <= tape_d;
            rate_q <= rate_d;
        end
    end

    // Drive status byte for the sense command, from the selected head and drive.
    always_comb begin
        st3 = {1'b0, ~wprot_n, 1'b1, ~trk0_n, 1'b1, host_wdata[2:0]};
    end

    // Command phase: collects parameters and loads the result bytes.
    always_comb begin
        phase_d = phase_q;
        cmd_d = cmd_q;
        pcnt_d = pcnt_q;
        rcnt_d = rcnt_q;
        ridx_d = ridx_q;
        standby_d = standby_q;
        spec_a_d = spec_a_q;
        spec_b_d = spec_b_q;
        res_d = res_q;
        case (phase_q)
            fdc_regs_pkg::PH_IDLE: begin
                if (fifo_wr) begin
                    cmd_d = host_wdata;
                    standby_d = 1'b0;
                    ridx_d = 4'h0;
                    pcnt_d = 2'h0;
                    if (host_wdata == fdc_regs_pkg::CMD_DUMP_REGS) begin
                        res_d[0] = present_cylinder[7:0];
                        res_d[1] = present_cylinder[15:8];
                        res_d[2] = present_cylinder[23:16];
                        res_d[3] = present_cylinder[31:24];
                        res_d[4] = spec_a_q;
                        res_d[5] = spec_b_q;
                        res_d[6] = sectors_per_track;
                        res_d[7] = perpendicular_settings;
                        res_d[8] = fifo_settings;
                        res_d[9] = precomp_start_track;
                        rcnt_d = fdc_regs_pkg::DUMP_COUNT;
                        phase_d = fdc_regs_pkg::PH_RESULT;
                    end else if (host_wdata == fdc_regs_pkg::CMD_SENSE_DRIVE ||
                                 host_wdata == fdc_regs_pkg::CMD_SPECIFY) begin
                        phase_d = fdc_regs_pkg::PH_PARAM;
                    end else begin
                        res_d[0] = fdc_regs_pkg::ST0_INVALID;
                        rcnt_d = fdc_regs_pkg::INVALID_COUNT;
                        standby_d = 1'b1;
                        phase_d = fdc_regs_pkg::PH_RESULT;
                    end
                end
            end
            fdc_regs_pkg::PH_PARAM: begin
                if (fifo_wr) begin
                    pcnt_d = pcnt_q + 2'h1;
                    if (cmd_q == fdc_regs_pkg::CMD_SENSE_DRIVE) begin
                        res_d[0] = st3;
                        rcnt_d = fdc_regs_pkg::SENSE_COUNT;
                        phase_d = fdc_regs_pkg::PH_RESULT;
                    end else if (pcnt_q == 2'h0) begin
                        spec_a_d = host_wdata;
                    end else begin
                        spec_b_d = host_wdata;
                        phase_d = fdc_regs_pkg::PH_IDLE;
                    end
                end
            end
            fdc_regs_pkg::PH_RESULT: begin
                if (fifo_rd) begin
                    ridx_d = ridx_q + 4'h1;
                    if (ridx_q == rcnt_q - 4'h1) begin
                        phase_d = fdc_regs_pkg::PH_IDLE;
                    end
                end
            end
            default: begin
                phase_d = fdc_regs_pkg::PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            phase_q <= fdc_regs_pkg::PH_IDLE;
            cmd_q <= 8'h00;
            pcnt_q <= 2'h0;
            rcnt_q <= 4'h0;
            ridx_q <= 4'h0;
            standby_q <= 1'b0;
            spec_a_q <= fdc_regs_pkg::SPECIFY_RESET;
            spec_b_q <= fdc_regs_pkg::SPECIFY_RESET;
            for (int i = 0; i < 10; i++) begin
                res_q[i] <= 8'h00;
            end
        end else begin
            phase_q <= phase_d;
            cmd_q <= cmd_d;
            pcnt_q <= pcnt_d;
            rcnt_q <= rcnt_d;
            ridx_q <= ridx_d;
            standby_q <= standby_d;
            spec_a_q <= spec_a_d;
            spec_b_q <= spec_b_d;
            res_q <= res_d;
        end
    end

    // Read data mux; one compatibility input picks both monitor layouts.
    logic [7:0] mon_a;
    logic [7:0] mon_b;
    logic [7:0] tape_rd;
    logic [7:0] rdata_d;
    logic [2:0] dtype_lsb;
    always_comb begin
        dtype_lsb = {do_q[1:0], 1'b0};
        if (alt_compat_mode) begin
            mon_a = {fdc_interrupt, transfer_request_pin, ~step_latch_q, ~trk0_n,
                     side_select_pin_n, ~index_n, ~wprot_n, ~step_inward};
            mon_b = {two_drv_n, drive_b_select_pin_n, drive_a_select_pin_n,
                     ~wd_level, ~rd_level, ~gate_latch_q,
                     drive_d_select_pin_n, drive_c_select_pin_n};
        end else begin
            mon_a = {fdc_interrupt, two_drv_n, ~step_pulse_pin_n, trk0_n,
                     ~side_select_pin_n, index_n, wprot_n, step_inward};
            mon_b = {2'b11, do_q[0], wd_toggle, rd_toggle,
                     ~write_gate_pin_n, ~motor_b_pin_n, ~motor_a_pin_n};
        end
        if (three_mode_enable) begin
            tape_rd = {media_boot_config_reg[3:2],
                       drive_type_config_reg[dtype_lsb +: 2],
                       media_boot_config_reg[1:0], tape_q};
        end else begin
            tape_rd = {6'h00, tape_q};
        end
        case (host_addr)
            fdc_regs_pkg::OFS_MONITOR_A: rdata_d = mon_a;
            fdc_regs_pkg::OFS_MONITOR_B: rdata_d = mon_b;
            fdc_regs_pkg::OFS_TAPE_ASSIGN: rdata_d = tape_rd;
            fdc_regs_pkg::OFS_STATUS_RATE: begin
                rdata_d = 8'h00;
                rdata_d[fdc_regs_pkg::MS_RQM_BIT] = 1'b1;
                rdata_d[fdc_regs_pkg::MS_DIO_BIT] = phase_q == fdc_regs_pkg::PH_RESULT;
                rdata_d[fdc_regs_pkg::MS_BUSY_BIT] = phase_q != fdc_regs_pkg::PH_IDLE;
            end
            fdc_regs_pkg::OFS_FIFO: begin
                rdata_d = phase_q == fdc_regs_pkg::PH_RESULT ? res_q[ridx_q] : 8'h00;
            end
            fdc_regs_pkg::OFS_INPUT_CONFIG: rdata_d = {~dskchg_n, 7'h00};
            default: rdata_d = 8'h00;
        endcase
    end

    // Read data register updates on each read strobe.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            host_rdata_q <= 8'h00;
        end else if (rd_en) begin
            host_rdata_q <= rdata_d;
        end
    end

    // Bus drive in the cycle after a read; write-only and unused offsets stay off.
    logic oe_q;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            oe_q <= 1'b0;
        end else begin
            oe_q <= rd_en && host_addr != fdc_regs_pkg::OFS_DRIVE_OUT && host_addr != 3'h6;
        end
    end
    assign host_rdata_oe = oe_q;

    // Drive-side outputs from the drive output register; data rate and standby from their own registers, non-DMA flag from bit 0 of the second specify byte.
    always_comb begin
        motor_a_pin_n = ~do_q[fdc_regs_pkg::DO_MOTOR_LSB];
        motor_b_pin_n = ~do_q[fdc_regs_pkg::DO_MOTOR_LSB + 1];
        drive_a_select_pin_n = do_q[1:0] != 2'h0;
        drive_b_select_pin_n = do_q[1:0] != 2'h1;
        drive_c_select_pin_n = do_q[1:0] != 2'h2;
        drive_d_select_pin_n = do_q[1:0] != 2'h3;
        dma_irq_enable = do_q[fdc_regs_pkg::DO_DMA_EN_BIT];
        controller_reset_n = do_q[fdc_regs_pkg::DO_RESET_N_BIT];
        data_rate = rate_q;
        non_dma_flag = spec_b_q[0];
        controller_standby = standby_q;
    end

    a_wo_no_drive: assert property (@(posedge clock) disable iff (rst)
        (rd_en && host_addr == fdc_regs_pkg::OFS_DRIVE_OUT) |=> !host_rdata_oe)
        else $error("write-only offset drove the bus");

    a_ro_ignores_write: assert property (@(posedge clock) disable iff (rst)
        (wr_en && host_addr <= fdc_regs_pkg::OFS_MONITOR_B) |=> $stable(do_q) && $stable(tape_q))
        else $error("write to a status offset changed state");

    a_invalid_result: assert property (@(posedge clock) disable iff (rst)
        (fifo_wr && phase_q == fdc_regs_pkg::PH_IDLE && host_wdata[7:6] == 2'b01)
        |=> res_q[0] == fdc_regs_pkg::ST0_INVALID && controller_standby &&
            phase_q == fdc_regs_pkg::PH_RESULT && rcnt_q == fdc_regs_pkg::INVALID_COUNT)
        else $error("invalid command did not answer 80 hex");

    a_sense_one_byte: assert property (@(posedge clock) disable iff (rst)
        (fifo_wr && phase_q == fdc_regs_pkg::PH_PARAM && cmd_q == fdc_regs_pkg::CMD_SENSE_DRIVE)
        |=> phase_q == fdc_regs_pkg::PH_RESULT && rcnt_q == 4'h1)
        else $error("sense drive status result count wrong");

    a_dump_count: assert property (@(posedge clock) disable iff (rst)
        (fifo_wr && phase_q == fdc_regs_pkg::PH_IDLE && host_wdata == fdc_regs_pkg::CMD_DUMP_REGS)
        |=> rcnt_q == 4'hA && res_q[6] == $past(sectors_per_track))
        else $error("dump result not loaded");

    a_tape_normal: assert property (@(posedge clock) disable iff (rst)
        (rd_en && host_addr == fdc_regs_pkg::OFS_TAPE_ASSIGN && !three_mode_enable)
        |=> host_rdata_q[7:2] == 6'h00 && host_rdata_q[1:0] == $past(tape_q))
        else $error("tape register upper bits not zero");

    a_media_id: assert property (@(posedge clock) disable iff (rst)
        (rd_en && host_addr == fdc_regs_pkg::OFS_TAPE_ASSIGN && three_mode_enable)
        |=> host_rdata_q[7:6] == $past(media_boot_config_reg[3:2]))
        else $error("media id bits wrong");

    a_monitor_irq: assert property (@(posedge clock) disable iff (rst)
        (rd_en && host_addr == fdc_regs_pkg::OFS_MONITOR_A) |=> host_rdata_q[7] == $past(fdc_interrupt))
        else $error("monitor A interrupt bit wrong");

    a_sel_mirror: assert property (@(posedge clock) disable iff (rst)
        (rd_en && host_addr == fdc_regs_pkg::OFS_MONITOR_B && !alt_compat_mode)
        |=> host_rdata_q[5] == $past(do_q[0]))
        else $error("monitor B select mirror wrong");

endmodule

// ===== sim/host_bus_model.sv
// Host processor model that makes one-cycle register strobes on the bus.
// Assumes the block takes strobes on the rising edge of the shared clock.
`timescale 1ns/1ps
module host_bus_model (
    output logic [2:0] host_addr,
    output logic host_cs,
    output logic host_rd,
    output logic host_wr,
    output logic [7:0] host_wdata,
    input wire logic clock
);
    // Idle bus with no strobe raised.
    initial begin
        host_addr = 3'h6;
        host_wdata = 8'h00;
        host_cs = 1'b0;
        host_rd = 1'b0;
        host_wr = 1'b0;
    end

    // Drive after a falling edge and hold through the rising edge that takes it.
    task automatic access(input logic wr, input logic [2:0] a, input logic [7:0] d);
        @(negedge clock);
        host_addr = a;
        host_wdata = d;
        host_cs = 1'b1;
        host_rd = ~wr;
        host_wr = wr;
        @(negedge clock);
        host_cs = 1'b0;
        host_rd = 1'b0;
        host_wr = 1'b0;
        host_addr = ~a; // Released lines scramble so stale values are never trusted.
        host_wdata = ~d;
    endtask
endmodule

// ===== sim/floppy_status_command_regs_test.sv
// Self-checking bench for the floppy register bank.
// Assumes host_bus_model makes the strobes; expected read answers are queued for a monitor.
`timescale 1ns/1ps
module floppy_status_command_regs_test;
    logic clock = 1'b0, rst = 1'b1, host_cs, host_rd, host_wr, host_rdata_oe;
    logic [2:0] host_addr;
    logic [7:0] host_wdata, host_rdata_q, drive_type_config_reg, media_boot_config_reg;
    logic alt_compat_mode = 1'b0, three_mode_enable = 1'b0, fdc_interrupt, step_inward;
    logic transfer_request_pin, step_pulse_pin_n, side_select_pin_n, write_gate_pin_n;
    logic write_data_pin_n = 1'b1, read_data_pin_n = 1'b1, second_drive_present_n;
    logic track_zero_input_n, index_pulse_signal_n, write_protect_input_n, disk_change_n;
    logic [31:0] present_cylinder;
    logic [7:0] sectors_per_track, perpendicular_settings, fifo_settings, precomp_start_track;
    logic motor_a_pin_n, motor_b_pin_n, drive_a_select_pin_n, drive_b_select_pin_n;
    logic drive_c_select_pin_n, drive_d_select_pin_n, dma_irq_enable, controller_reset_n;
    logic [1:0] data_rate;
    logic non_dma_flag, controller_standby, wd_t = 1'b0, rd_t = 1'b0;
    logic [7:0] do_q, p1, p2, tail[6], exp_q[$];
    int n_fail = 0, comparisons = 0;

    floppy_status_command_regs DUT (.*);
    host_bus_model u_host (.*);

    // Free-running 40 MHz clock.
    always #12.5 clock = ~clock;

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        comparisons++;
        if (s !== e) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // New random pin levels; rising edges of the data pins are counted as toggles.
    task automatic set_pins();
        logic ow, orr;
        ow = write_data_pin_n;
        orr = read_data_pin_n;
        {fdc_interrupt, transfer_request_pin, step_pulse_pin_n, step_inward, side_select_pin_n,
            write_gate_pin_n, write_data_pin_n, read_data_pin_n, second_drive_present_n,
            track_zero_input_n, index_pulse_signal_n, write_protect_input_n, disk_change_n}
            = 13'($urandom);
        {drive_type_config_reg, media_boot_config_reg, sectors_per_track} = 24'($urandom);
        {perpendicular_settings, fifo_settings, precomp_start_track} = 24'($urandom);
        present_cylinder = $urandom;
        if (!ow && write_data_pin_n) wd_t = ~wd_t;
        if (!orr && read_data_pin_n) rd_t = ~rd_t;
        repeat (5) @(negedge clock);
    endtask

    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        u_host.access(1'b0, a, 8'h00);
    endtask

    function automatic logic [7:0] outs();
        return {controller_reset_n, drive_a_select_pin_n, drive_b_select_pin_n,
            drive_c_select_pin_n, drive_d_select_pin_n, motor_b_pin_n, motor_a_pin_n, dma_irq_enable};
    endfunction

    function automatic logic [7:0] exp_a();
        if (alt_compat_mode) return {fdc_interrupt, transfer_request_pin, ~step_pulse_pin_n,
            ~track_zero_input_n, side_select_pin_n, ~index_pulse_signal_n,
            ~write_protect_input_n, ~step_inward};
        return {fdc_interrupt, second_drive_present_n, ~step_pulse_pin_n, track_zero_input_n,
            ~side_select_pin_n, index_pulse_signal_n, write_protect_input_n, step_inward};
    endfunction

    function automatic logic [7:0] exp_b();
        if (alt_compat_mode) return {second_drive_present_n, do_q[1:0] != 2'h1,
            do_q[1:0] != 2'h0, ~write_data_pin_n, ~read_data_pin_n, ~write_gate_pin_n,
            do_q[1:0] != 2'h3, do_q[1:0] != 2'h2};
        return {2'b11, do_q[0], wd_t, rd_t, ~write_gate_pin_n, do_q[5], do_q[4]};
    endfunction

    // Each read answer is compared with the oldest queued expectation.
    always @(negedge clock) begin
        if (host_rdata_oe === 1'b1) begin
            if (exp_q.size() == 0) begin
                n_fail++;
                $display("unexpected read enable expected 0 seen 1");
            end else begin
                chk("read data", exp_q.pop_front(), host_rdata_q);
            end
        end
    end

    // Cuts a hang short well after the tests should have ended.
    initial begin
        #200000;
        n_fail++;
        final_report();
    end

    // Main sequence: reset, pin monitors, tape register, then commands.
    initial begin
        p1 = 8'($urandom(32'hB8C2));
        set_pins();
        write_data_pin_n = 1'b1;
        read_data_pin_n = 1'b1;
        repeat (3) @(negedge clock);
        rst = 1'b0;
        chk("reset outputs", 8'h3E, outs());
        for (int i = 0; i < 4; i++) begin
            do_q = {2'b00, 2'($urandom), 2'b11, 2'($urandom)};
            u_host.access(1'b1, 3'h2, do_q);
            u_host.access(1'b1, 3'h0, 8'($urandom));
            u_host.access(1'b0, 3'h2, 8'h00);
            alt_compat_mode = i[0];
            set_pins();
            chk("drive pins", {do_q[2], do_q[1:0] != 2'h0, do_q[1:0] != 2'h1, do_q[1:0] != 2'h2,
                do_q[1:0] != 2'h3, ~do_q[5], ~do_q[4], do_q[3]}, outs());
            rd(3'h0, exp_a());
            rd(3'h1, exp_b());
        end
        for (int t = 0; t < 8; t++) begin
            three_mode_enable = t[2];
            p1 = 8'($urandom);
            u_host.access(1'b1, 3'h3, {p1[7:2], t[1:0]});
            rd(3'h3, t[2] ? {media_boot_config_reg[3:2], drive_type_config_reg[{do_q[1:0], 1'b0}
                +: 2], media_boot_config_reg[1:0], t[1:0]} : {6'h00, t[1:0]});
        end
        p1 = 8'($urandom);
        p2 = 8'($urandom);
        u_host.access(1'b1, 3'h5, fdc_regs_pkg::CMD_SPECIFY);
        u_host.access(1'b1, 3'h5, p1);
        u_host.access(1'b1, 3'h5, p2);
        chk("non dma flag", {7'h00, p2[0]}, {7'h00, non_dma_flag});
        u_host.access(1'b1, 3'h7, p2);
        chk("data rate", {6'h00, p2[1:0]}, {6'h00, data_rate});
        u_host.access(1'b1, 3'h5, fdc_regs_pkg::CMD_DUMP_REGS);
        for (int k = 0; k < 4; k++) rd(3'h5, present_cylinder[8*k +: 8]);
        tail = '{p1, p2, sectors_per_track, perpendicular_settings, fifo_settings,
            precomp_start_track};
        foreach (tail[k]) rd(3'h5, tail[k]);
        p1 = {5'h00, 3'($urandom)};
        u_host.access(1'b1, 3'h5, fdc_regs_pkg::CMD_SENSE_DRIVE);
        u_host.access(1'b1, 3'h5, p1);
        rd(3'h5, {1'b0, ~write_protect_input_n, 1'b1, ~track_zero_input_n, 1'b1, p1[2:0]});
        u_host.access(1'b1, 3'h5, {2'b01, 6'($urandom)});
        chk("standby", 8'h01, {7'h00, controller_standby});
        rd(3'h4, 8'hD0);
        rd(3'h5, fdc_regs_pkg::ST0_INVALID);
        rd(3'h7, {~disk_change_n, 7'h00});
        repeat (4) @(negedge clock);
        chk("pending reads", 8'h00, 8'(exp_q.size()));
        final_report();
    end
endmodule
